// ===== rtl/flash_host.sv
// Host controller driving a flash bus: secured region, query mode, program
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ps
`include "flash_host_map.svh"
module flash_host import flash_host_pkg::*; #(
   parameter int DUMP_DEPTH = `CFI_WORDS
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [31:0] dq_i,
   input wire logic flash_ready_i,
   input wire logic supply_lockout_i,
   output pins_t flash_o
);
   if (DUMP_DEPTH != `CFI_WORDS) begin : g_bad_depth
      $error("flash_host: the dump sequence serves exactly the fixed table");
   end

   localparam logic [7:0] WE_C = 8'(`WE_CYC);
   localparam logic [7:0] RD_C = 8'(`RD_CYC);
   localparam logic [7:0] RST_C = 8'(`RST_CYC);
   localparam logic [7:0] BUSY_C = 8'(`BUSY_CYC);
   localparam pins_t PINS_IDLE = '{cs_b: 1'b1, we_b: 1'b1, oe_b: 1'b1,
      dq_oe_b: 1'b1, rst_b: 1'b1, addr: '0, dq: '0};
   localparam pins_t PINS_RST = '{cs_b: 1'b1, we_b: 1'b1, oe_b: 1'b1,
      dq_oe_b: 1'b1, rst_b: 1'b0, addr: '0, dq: '0};

   // ----------------------------------------
   // Step table
   // ----------------------------------------
   // Command write: the byte in the low lane of both 16-bit dies
   function automatic step_t cw(logic [22:0] a, logic [7:0] c);
      return '{kind: K_WR, addr: a, data: {8'h00, c, 8'h00, c}};
   endfunction : cw

   function automatic step_t step_of(op_t op, logic [5:0] i, logic [22:0] a, logic [31:0] d);
      step_t s;
      logic unl;
      s = '{kind: K_END, addr: '0, data: '0};
      unl = (op == OP_PROG) || (op == OP_ENTER) || (op == OP_EXIT) || (op == OP_IND); // Never bypass
      if (unl && i == 6'h00) begin
         s = cw(`FA_UNLOCK1, `FC_UNLOCK1);
      end else if (unl && i == 6'h01) begin
         s = cw(`FA_UNLOCK2, `FC_UNLOCK2);
      end else begin
         case (op)
            OP_READ: if (i == 6'h00) s = '{kind: K_RD, addr: a, data: '0};
            OP_WRITE: if (i == 6'h00) s = '{kind: K_WR, addr: a, data: d};
            OP_PROG: begin
               if (i == 6'h02) s = cw(`FA_UNLOCK1, `FC_PROGRAM);
               if (i == 6'h03) s = '{kind: K_WR, addr: a, data: d};
            end
            OP_ENTER: if (i == 6'h02) s = cw(`FA_UNLOCK1, `FC_SEC_ENTER);
            OP_EXIT: begin
               if (i == 6'h02) s = cw(`FA_UNLOCK1, `FC_SEC_EXIT);
               if (i == 6'h03) s = cw(`FA_ZERO, `FC_EXIT_END);
            end
            OP_IND: begin
               if (i == 6'h02) s = cw(`FA_UNLOCK1, `FC_SEC_EXIT);
               if (i == 6'h03) s = '{kind: K_RD, addr: `FA_INDICATOR, data: '0};
               if (i == 6'h04) s = cw(`FA_ZERO, `FC_RESET);
            end
            OP_QUERY: if (i == 6'h00) s = cw(`FA_QUERY, `FC_QUERY);
            OP_RESET: if (i == 6'h00) s = cw(`FA_ZERO, `FC_RESET);
            OP_DUMP: begin
               if (i == 6'h00) s = cw(`FA_QUERY, `FC_QUERY);
               if (i >= 6'h01 && i <= 6'(`CFI_WORDS)) begin
                  s = '{kind: K_RD, addr: 23'(`CFI_FIRST) + 23'(i) - 23'h1, data: '0};
               end
               if (i == 6'(`CFI_WORDS + 1)) s = cw(`FA_ZERO, `FC_RESET);
            end
            default: s = '{kind: K_END, addr: '0, data: '0};
         endcase
      end
      return s;
   endfunction : step_of

   state_t state_r;
   op_t op_r;
   pins_t pins_r;
   logic [5:0] idx_r;
   logic [7:0] cnt_r;
   logic [22:0] addr_r;
   logic [31:0] wdata_r, rdata_r, prdata_r;
   logic in_sec_r, in_query_r, refused_r, fac_r, usr_r, mismatch_r;
   logic pready_r, pslverr_r;
   logic [31:0] dump_q;

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   logic acc, wr_take, rd_phase, ctrl_hit, stat_hit, dump_hit, mapped, go, refuse, start_ok;
   logic legal, is_query, sec_bad, user_bad, capture, last_step;
   op_t new_op;
   step_t cur;
   logic [31:0] status, rd_mux;
   assign acc = psel_i && penable_i;
   assign wr_take = acc && pwrite_i && pready_r;
   assign rd_phase = acc && !pready_r;
   assign ctrl_hit = paddr_i == `REG_CTRL;
   assign stat_hit = paddr_i == `REG_STATUS;
   assign dump_hit = paddr_i[11:8] == `REG_DUMP_PAGE && int'(paddr_i[7:2]) < DUMP_DEPTH;
   assign mapped = ctrl_hit || stat_hit || dump_hit || paddr_i == `REG_ADDR ||
      paddr_i == `REG_WDATA || paddr_i == `REG_RDATA;

   // Order checks: refused orders never reach the flash pins
   assign new_op = op_t'(pwdata_i[3:0]);
   assign legal = pwdata_i[3:0] != 4'h0 && pwdata_i[3:0] <= 4'h9;
   assign is_query = new_op == OP_QUERY || new_op == OP_DUMP;
   assign sec_bad = in_sec_r && addr_r > `FA_SEC_LAST;
   assign user_bad = in_sec_r && (addr_r < `FA_USER_FIRST || addr_r > `FA_USER_LAST || usr_r);
   assign go = wr_take && ctrl_hit;
   assign refuse = !legal || state_r != ST_IDLE || supply_lockout_i
      || (is_query && !flash_ready_i)
      || ((new_op == OP_READ || new_op == OP_PROG) && sec_bad)
      || (new_op == OP_PROG && (user_bad || in_query_r));
   assign start_ok = go && !refuse;

   assign cur = step_of(op_r, idx_r, addr_r, wdata_r);
   assign capture = state_r == ST_PULSE && cnt_r == 8'h00 && !pins_r.oe_b;
   assign last_step = state_r == ST_LOAD && cur.kind == K_END;

   assign status = {23'h0, mismatch_r, flash_ready_i, supply_lockout_i, usr_r, fac_r,
      refused_r, in_query_r, in_sec_r, state_r != ST_IDLE};
   assign rd_mux = ctrl_hit ? {28'h0, op_r} :
      paddr_i == `REG_ADDR ? {9'h0, addr_r} :
      paddr_i == `REG_WDATA ? wdata_r :
      stat_hit ? status :
      paddr_i == `REG_RDATA ? rdata_r :
      dump_hit ? dump_q : 32'h0;

   cfi_store #(.WIDTH(32), .DEPTH(DUMP_DEPTH), .AW(6)) u_store (
      .mclk_i(mclk_i),
      .ce_i(ce_i),
      .wr_i(capture && op_r == OP_DUMP),
      .waddr_i(idx_r - 6'h01),
      .wdata_i(dq_i),
      .raddr_i(paddr_i[7:2]),
      .rdata_o(dump_q)
   );

   // ----------------------------------------
   // APB slave: one wait state on every transfer
   // ----------------------------------------
   // The wait state gives the table memory its registered read cycle
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= '0;
      end else if (ce_i) begin
         pready_r <= rd_phase;
         pslverr_r <= rd_phase && !mapped;
         if (rd_phase) prdata_r <= mapped ? rd_mux : 32'h0;
      end
   end

   // Software-written operands
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         addr_r <= '0;
         wdata_r <= '0;
         op_r <= OP_NONE;
      end else if (ce_i) begin
         if (wr_take && paddr_i == `REG_ADDR && state_r == ST_IDLE) addr_r <= pwdata_i[22:0];
         if (wr_take && paddr_i == `REG_WDATA && state_r == ST_IDLE) wdata_r <= pwdata_i;
         if (start_ok) op_r <= new_op;
      end
   end

   // ----------------------------------------
   // Mode tracking and captured results
   // ----------------------------------------
   // Refusal is sticky; a new refusal in the clearing cycle wins
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         in_sec_r <= 1'b0;
         in_query_r <= 1'b0;
         refused_r <= 1'b0;
         fac_r <= 1'b0;
         usr_r <= 1'b0;
         mismatch_r <= 1'b0;
         rdata_r <= '0;
      end else if (ce_i) begin
         if (go && refuse) refused_r <= 1'b1;
         else if (wr_take && stat_hit && pwdata_i[`ST_REFUSED_BIT]) refused_r <= 1'b0;
         if (supply_lockout_i) begin
            in_sec_r <= 1'b0;
            in_query_r <= 1'b0;
         end else if (last_step) begin
            if (op_r == OP_ENTER) in_sec_r <= 1'b1;
            if (op_r == OP_EXIT) in_sec_r <= 1'b0;
            if (op_r == OP_QUERY) in_query_r <= 1'b1;
            if (op_r == OP_RESET || op_r == OP_DUMP) in_query_r <= 1'b0;
         end
         if (capture) begin
            rdata_r <= dq_i;
            if (op_r == OP_IND) begin
               fac_r <= dq_i[7];
               usr_r <= dq_i[6];
            end
            if (op_r == OP_DUMP && dq_i[31:16] != dq_i[15:0]) mismatch_r <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Bus cycle sequencer
   // ----------------------------------------
   // Address and data stay put from setup to hold, so the later falling
   // and earlier rising strobe edges both see stable values
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_r <= ST_FRST;
         pins_r <= PINS_RST;
         idx_r <= '0;
         cnt_r <= RST_C;
      end else if (ce_i) begin
         if (supply_lockout_i && state_r != ST_FRST) begin
            state_r <= ST_IDLE;
            pins_r <= PINS_IDLE;
         end else begin
            unique case (state_r)
               ST_FRST: begin
                  cnt_r <= cnt_r - 8'h01;
                  if (cnt_r == 8'h00) begin
                     pins_r.rst_b <= 1'b1;
                     state_r <= ST_IDLE;
                  end
               end
               ST_IDLE: begin
                  idx_r <= '0;
                  if (start_ok) state_r <= ST_LOAD;
               end
               ST_LOAD: begin
                  if (cur.kind == K_END) begin
                     cnt_r <= BUSY_C;
                     state_r <= (op_r == OP_PROG) ? ST_BUSY : ST_IDLE;
                  end else begin
                     pins_r.cs_b <= 1'b0;
                     pins_r.addr <= cur.addr;
                     pins_r.dq <= cur.data;
                     pins_r.dq_oe_b <= cur.kind != K_WR;
                     state_r <= ST_SETUP;
                  end
               end
               ST_SETUP: begin
                  pins_r.we_b <= pins_r.dq_oe_b;
                  pins_r.oe_b <= !pins_r.dq_oe_b;
                  cnt_r <= (pins_r.dq_oe_b ? RD_C : WE_C) - 8'h01;
                  state_r <= ST_PULSE;
               end
               ST_PULSE: begin
                  cnt_r <= cnt_r - 8'h01;
                  if (cnt_r == 8'h00) begin
                     pins_r.we_b <= 1'b1;
                     pins_r.oe_b <= 1'b1;
                     state_r <= ST_HOLD;
                  end
               end
               ST_HOLD: begin
                  pins_r.cs_b <= 1'b1;
                  pins_r.dq_oe_b <= 1'b1;
                  idx_r <= idx_r + 6'h01;
                  state_r <= ST_LOAD;
               end
               ST_BUSY: begin
                  // Ready may lag the last write, so it is only trusted after a delay
                  if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
                  else if (flash_ready_i) state_r <= ST_IDLE;
               end
            endcase
         end
      end
   end

   assign prdata_o = prdata_r;
   assign pready_o = pready_r;
   assign pslverr_o = pslverr_r;
   assign flash_o = pins_r;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   logic [2:0] wr_cnt_r;
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) wr_cnt_r <= '0;
      else if (ce_i && state_r == ST_IDLE) wr_cnt_r <= '0;
      else if (ce_i && state_r == ST_SETUP && !pins_r.dq_oe_b && wr_cnt_r != 3'h7) wr_cnt_r <= wr_cnt_r + 3'h1;
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);

   a_write_strobe: assert property (!pins_r.we_b |-> !pins_r.cs_b && pins_r.oe_b)
      else $error("write strobe without select or with output enable");
   a_strobe_stable: assert property (!pins_r.we_b && $past(!pins_r.we_b) |->
      $stable(pins_r.addr) && $stable(pins_r.dq))
      else $error("address or data moved under write strobe");
   a_reset_quiet: assert property (state_r == ST_FRST |-> pins_r.we_b && pins_r.cs_b && !in_sec_r)
      else $error("strobe or secured mode during flash reset");
   a_reset_clears: assert property ($rose(rst_b_i) |-> !in_sec_r && !in_query_r)
      else $error("mode flag survived reset");
   a_lockout_quiet: assert property (ce_i && supply_lockout_i |=> pins_r.we_b && !in_sec_r)
      else $error("write strobe under supply lockout");
   a_query_busy: assert property (ce_i && go && is_query && !flash_ready_i |=>
      refused_r && !(state_r == ST_LOAD && $past(state_r) == ST_IDLE))
      else $error("query entered while flash busy");
   a_unlock_first: assert property (state_r == ST_SETUP && op_r == OP_PROG && idx_r == 6'h03 |->
      wr_cnt_r == 3'h3)
      else $error("program data without unlock cycles");
   a_query_cmd: assert property (state_r == ST_PULSE && op_r == OP_QUERY |->
      pins_r.addr == `FA_QUERY && pins_r.dq[7:0] == `FC_QUERY)
      else $error("query command malformed");
   a_cmd_halves: assert property (!pins_r.dq_oe_b && op_r != OP_WRITE && !(op_r == OP_PROG && idx_r == 6'h03) |->
      pins_r.dq[31:16] == pins_r.dq[15:0] && pins_r.dq[15:8] == 8'h00)
      else $error("command not in low byte of both halves");
   a_sec_bounds: assert property (state_r == ST_SETUP && in_sec_r && op_r == OP_PROG && idx_r == 6'h03 |->
      pins_r.addr >= `FA_USER_FIRST && pins_r.addr <= `FA_USER_LAST)
      else $error("secured program outside user area");
   a_reset_exits: assert property (ce_i && last_step && op_r == OP_RESET && !supply_lockout_i |=> !in_query_r)
      else $error("query mode kept after reset command");
   a_lock_once: assert property (ce_i && go && new_op == OP_PROG && in_sec_r && usr_r |=> refused_r)
      else $error("program into locked secured region");

   c_dump_done: cover property (last_step && op_r == OP_DUMP);
   c_sec_enter: cover property ($rose(in_sec_r));
   c_prog_done: cover property (state_r == ST_BUSY ##1 state_r == ST_IDLE);
   c_refused: cover property ($rose(refused_r));
endmodule : flash_host

// ===== pkg/flash_host_map.svh
// Register offsets, flash command codes and timing counts of the flash host
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH
// ----------------------------------------
// Controller registers (APB byte offsets)
// ----------------------------------------
`define REG_CTRL 12'h000
`define REG_ADDR 12'h004
`define REG_WDATA 12'h008
`define REG_STATUS 12'h00c
`define REG_RDATA 12'h010
`define REG_DUMP_PAGE 4'h1
// Status bit positions
`define ST_BUSY_BIT 0
`define ST_SEC_BIT 1
`define ST_QUERY_BIT 2
`define ST_REFUSED_BIT 3
`define ST_FACTORY_BIT 4
`define ST_USER_BIT 5
`define ST_LOCKOUT_BIT 6
`define ST_READY_BIT 7
`define ST_MISMATCH_BIT 8
// ----------------------------------------
// Flash addresses and command bytes
// ----------------------------------------
`define FA_UNLOCK1 23'h000555
`define FA_UNLOCK2 23'h0002aa
`define FA_QUERY 23'h000055
`define FA_ZERO 23'h000000
`define FA_INDICATOR 23'h000003
`define FA_SEC_LAST 23'h00007f
`define FA_USER_FIRST 23'h000040
`define FA_USER_LAST 23'h00007e
`define FC_UNLOCK1 8'haa
`define FC_UNLOCK2 8'h55
`define FC_PROGRAM 8'ha0
`define FC_SEC_ENTER 8'h88
`define FC_SEC_EXIT 8'h90
`define FC_EXIT_END 8'h00
`define FC_RESET 8'hf0
`define FC_QUERY 8'h98
`define CFI_FIRST 8'h10
`define CFI_WORDS 45
// ----------------------------------------
// Timing (ns figures, cycle counts at 8 ns)
// ----------------------------------------
`define CLK_NS 8
`define WE_PULSE_NS 40
`define RD_ACC_NS 120
`define RST_PULSE_NS 500
`define BUSY_START_NS 100
`define NS2CYC(ns) (((ns) + `CLK_NS - 1) / `CLK_NS)
`define WE_CYC `NS2CYC(`WE_PULSE_NS)
`define RD_CYC `NS2CYC(`RD_ACC_NS)
`define RST_CYC `NS2CYC(`RST_PULSE_NS)
`define BUSY_CYC `NS2CYC(`BUSY_START_NS)
`endif

// ===== pkg/flash_host_pkg.sv
// Types shared by the flash host controller
package flash_host_pkg;
   typedef enum logic [3:0] {
      OP_NONE, OP_READ, OP_PROG, OP_WRITE, OP_ENTER, OP_EXIT,
      OP_QUERY, OP_RESET, OP_DUMP, OP_IND
   } op_t;
   typedef enum logic [1:0] {K_END, K_WR, K_RD} kind_t;
   typedef struct packed {
      kind_t kind;
      logic [22:0] addr;
      logic [31:0] data;
   } step_t;
   typedef struct packed {
      logic cs_b;
      logic we_b;
      logic oe_b;
      logic dq_oe_b;
      logic rst_b;
      logic [22:0] addr;
      logic [31:0] dq;
   } pins_t;
   typedef enum logic [2:0] {
      ST_FRST, ST_IDLE, ST_LOAD, ST_SETUP, ST_PULSE, ST_HOLD, ST_BUSY
   } state_t;
endpackage : flash_host_pkg

// ===== rtl/cfi_store.sv
// Small memory holding the captured query table, registered read port
`timescale 1ns/1ps
module cfi_store #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 45,
   parameter int AW = 6
) (
   input wire logic mclk_i,
   input wire logic ce_i,
   input wire logic wr_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [WIDTH-1:0] wdata_i,
   input wire logic [AW-1:0] raddr_i,
   output logic [WIDTH-1:0] rdata_o
);
   if (DEPTH > (1 << AW)) begin : g_bad_depth
      $error("cfi_store: DEPTH does not fit AW");
   end
   logic [WIDTH-1:0] mem_r [DEPTH];
   // ----------------------------------------
   // Write port and registered read
   // ----------------------------------------
   // No reset: contents are only meaningful after a dump fills them
   always_ff @(posedge mclk_i) begin
      if (ce_i) begin
         if (wr_i && (int'(waddr_i) < DEPTH)) begin
            mem_r[waddr_i] <= wdata_i;
         end
         rdata_o <= (int'(raddr_i) < DEPTH) ? mem_r[raddr_i] : '0;
      end
   end
endmodule : cfi_store

// ===== testbench/flash_dev_model.sv
// Behavioural flash device: command decoder, secured region and query table
`timescale 1ns/1ps
module flash_dev_model import flash_host_pkg::*; #(
   parameter int PROG_CYC = 30
) (
   input wire logic mclk_i,
   input wire pins_t pins_i,
   input wire logic lockout_i,
   output logic [31:0] dq_o,
   output logic ready_o
);
   // ----------------------------------------
   // Query bytes for offsets 0x10 up to 0x3c
   // ----------------------------------------
   localparam logic [359:0] CFI = {64'h5152590200400000, 64'h0000002736000004, 64'h0009000500040018,
      64'h0100000003070020, 64'h00fd000001070020, 40'h0000000000};
   logic [15:0] mem [128];
   logic [1:0] unl_r;
   logic sec_r, qry_r, auto_r, prog_r, we_d_r, user_lock_r;
   int busy_r;
   logic [15:0] v;
   wire logic [22:0] a = pins_i.addr;
   wire logic [7:0] d = pins_i.dq[7:0];
   // Read mux; a deselected bus shows the inverse so stale data never passes
   assign v = qry_r ? {8'h00, CFI[359 - 8 * (int'(a) - 16) -: 8]}
      : (auto_r && a == 23'h3) ? {8'h00, 1'b1, user_lock_r, 6'h00}
      : sec_r ? mem[a[6:0]] : a[15:0] ^ 16'h5a5a;
   assign dq_o = (!pins_i.cs_b && !pins_i.oe_b) ? {v, v} : ~{v, v};
   assign ready_o = (busy_r == 0);
   // User lock never set here, so the user area stays writable for every program
   initial begin
      user_lock_r = 1'b0;
      busy_r = 0;
      for (int i = 0; i < 128; i++) mem[i] = 16'hc000 | 16'(i);
   end
   // Writes taken on the rising write strobe; busy and lockout ignore them
   always @(posedge mclk_i) begin
      we_d_r <= pins_i.we_b;
      if (busy_r > 0) busy_r <= busy_r - 1;
      if (!pins_i.rst_b) begin
         {sec_r, qry_r, auto_r, prog_r, unl_r} <= '0;
      end else if (pins_i.we_b && !we_d_r && !pins_i.cs_b && pins_i.oe_b
                   && !lockout_i && busy_r == 0) begin
         unl_r <= (a == 23'h555 && d == 8'haa) ? 2'd1 : (unl_r == 2'd1 && a == 23'h2aa && d == 8'h55) ? 2'd2 : 2'd0;
         if (prog_r) begin
            prog_r <= 1'b0;
            busy_r <= PROG_CYC;
            if (sec_r && a >= 23'h40 && a <= 23'h7e && !user_lock_r) mem[a[6:0]] <= pins_i.dq[15:0];
         end else if (unl_r == 2'd2 && a == 23'h555) begin
            prog_r <= (d == 8'ha0);
            auto_r <= (d == 8'h90);
            if (d == 8'h88) sec_r <= 1'b1;
         end else if (d == 8'h98 && a == 23'h55) begin
            qry_r <= 1'b1;
         end else if (d == 8'hf0) begin
            {qry_r, auto_r} <= 2'b00;
         end else if (auto_r && d == 8'h00) begin
            {sec_r, auto_r} <= 2'b00;
         end
      end
   end
endmodule : flash_dev_model

// ===== testbench/flash_host_tb_top.sv
// Self-checking bench: APB sequences against the flash device model
`timescale 1ns/1ps
`include "flash_host_map.svh"
module flash_host_tb_top import flash_host_pkg::*;;
   logic mclk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lockout = 1'b0, ce = 1'b1, pready, pslverr, frdy, err;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, dq, rd;
   pins_t pins;
   int n_mismatch = 0, n_tests = 0;
   always #4 mclk_i = ~mclk_i;
   flash_host i_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .dq_i(dq), .flash_ready_i(frdy), .supply_lockout_i(lockout), .flash_o(pins));
   flash_dev_model i_flash (.mclk_i(mclk_i), .pins_i(pins), .lockout_i(lockout), .dq_o(dq), .ready_o(frdy));
   // ----------------------------------------
   // Bus tasks and comparisons
   // ----------------------------------------
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic hang();
      n_mismatch++;
      test_done();
   endtask : hang
   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge mclk_i);
      penable <= 1'b1;
      for (int n = 0; n < 20; n++) begin
         @(posedge mclk_i);
         if (pready === 1'b1) break;
         if (n == 19) hang();
      end
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   // Polls status until not busy; rd then holds the status word
   task automatic wait_idle();
      for (int n = 0; n < 2000; n++) begin
         apb(1'b0, `REG_STATUS, '0);
         if (rd[`ST_BUSY_BIT] === 1'b0) return;
      end
      hang();
   endtask : wait_idle
   task automatic op(input logic [3:0] c, input logic [22:0] a, input logic [31:0] wd);
      apb(1'b1, `REG_ADDR, {9'h000, a});
      apb(1'b1, `REG_WDATA, wd);
      apb(1'b1, `REG_CTRL, {28'h0000000, c});
      wait_idle();
   endtask : op
   task automatic rdq(input logic [22:0] a, input logic [31:0] exp);
      op(4'h1, a, '0);
      apb(1'b0, `REG_RDATA, '0);
      chk(rd, exp);
   endtask : rdq
   // Main sequence: reset, query table, query mode, secured region, lockout
   initial begin
      repeat (20) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      wait_idle();
      chk(rd & 32'h46, 32'h0);
      $display("Test reset done");
      op(4'h8, '0, '0);
      chk(rd & 32'h10e, 32'h0);
      for (int i = 0; i < 45; i++) begin
         apb(1'b0, 12'h100 + 12'(4 * i), '0);
         chk(rd, {2{8'h00, i_flash.CFI[359 - 8 * i -: 8]}});
      end
      $display("Test query dump done");
      op(4'h6, '0, '0);
      chk(rd & 32'h4, 32'h4);
      rdq(23'h11, 32'h00520052);
      op(4'h7, '0, '0);
      chk(rd & 32'h4, 32'h0);
      op(4'h9, '0, '0);
      chk(rd & 32'h30, 32'h10);
      // Raw program sequence leaves the flash busy; a query must then be refused
      op(4'h3, 23'h555, 32'h00aa00aa);
      op(4'h3, 23'h2aa, 32'h00550055);
      op(4'h3, 23'h555, 32'h00a000a0);
      op(4'h3, 23'h200, 32'h0000abcd);
      op(4'h6, '0, '0);
      chk(rd & 32'hc, 32'h8);
      apb(1'b1, `REG_STATUS, 32'h8);
      repeat (40) @(posedge mclk_i);
      wait_idle();
      chk(rd & 32'h8c, 32'h80);
      $display("Test query mode done");
      op(4'h4, '0, '0);
      chk(rd & 32'h2, 32'h2);
      rdq(23'h10, 32'hc010c010);
      op(4'h2, 23'h45, 32'h12341234);
      rdq(23'h45, 32'h12341234);
      op(4'h2, 23'h10, '0);
      chk(rd & 32'h8, 32'h8);
      op(4'h5, '0, '0);
      chk(rd & 32'h2, 32'h0);
      rdq(23'h10, 32'h5a4a5a4a);
      // Clock enable low freezes a started read before its first bus cycle
      apb(1'b1, `REG_ADDR, 32'h20);
      apb(1'b1, `REG_CTRL, 32'h1);
      ce <= 1'b0;
      repeat (40) @(posedge mclk_i);
      chk({31'h0, pins.cs_b}, 32'h1);
      ce <= 1'b1;
      wait_idle();
      apb(1'b0, `REG_RDATA, '0);
      chk(rd, 32'h5a7a5a7a);
      // Hardware reset in mid-run drops secured mode in host and flash
      op(4'h4, '0, '0);
      rst_b_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      wait_idle();
      chk(rd & 32'h2, 32'h0);
      rdq(23'h10, 32'h5a4a5a4a);
      $display("Test secured region done");
      lockout <= 1'b1;
      apb(1'b1, `REG_STATUS, 32'h8);
      op(4'h1, '0, '0);
      chk(rd & 32'h48, 32'h48);
      lockout <= 1'b0;
      apb(1'b0, 12'h0f0, '0);
      chk({31'h0, err}, 32'h1);
      $display("Test lockout done");
      test_done();
   end
endmodule : flash_host_tb_top
